/* File: rtl/vectored_irq_and_free_timer.sv */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - 12-bit timer counts 1 MHz ticks
// - timer gives 128 us and 1.024 ms sources
// - interrupt on rising timer bit 6, 9
// - low-byte read latches upper timer nibble
// - high read returns latched nibble, not live
// - eleven maskable sources, each own vector
// - reset vector is address zero
// - bus reset 0x0002, timers 0x0004, 0x0006
// - endpoints 0-4 vector 0x0008 to 0x0010
// - 0x0012 reserved, user code from 0x001A
// - any sink port pin raises 0x0014
// - all gpio pins share vector 0x0016
// - endpoint events raise endpoint interrupts
// - per-pin mask on sink port inputs
// - per-pin mask on gpio inputs
// - per-pin edge choice on sink port
// - per-port edge choice on gpio
// - polarity picks rising or falling edge
// - sink port enables, write-only at 0x31
// - sink port edges, write-only at 0x32
// - endpoint enables read-write at 0x21
// - any reset clears all interrupt enables
// - early bus reset waits for enables
// - high timer byte top nibble reads zero
module vectored_irq_and_free_timer
   import irq_timer_pkg::*;
#(
   parameter int SINK_W     = 8,
   parameter int GPIO_PORTS = 4
) (
   input  wire logic                      ref_clk_i,       // 100 MHz clock
   input  wire logic                      rst_n_i,         // power-on or watchdog reset
   input  wire irq_timer_pkg::reg_req_s   reg_req_i,       // register access
   output logic [7:0]                     reg_rdata_o,     // read data, next cycle
   input  wire logic                      bus_reset_evt_i, // usb bus reset pulse
   input  wire logic [4:0]                ep_evt_i,        // endpoint done pulses
   input  wire logic                      i2c_evt_i,       // two-wire done pulse
   input  wire logic [SINK_W-1:0]         sink_pin_i,      // sink port pins
   input  wire logic [GPIO_PORTS*8-1:0]   gpio_pin_i,      // gpio port pins
   input  wire logic                      global_en_i,     // core global enable flag
   input  wire logic                      irq_ack_i,       // core takes vector
   output irq_timer_pkg::irq_vec_s        irq_o            // request and vector
);
   import irq_timer_pkg::*;

   localparam int GPIO_W = GPIO_PORTS * 8;

   ////////////////////////////////////////////////////////////////////////
   // register state

   logic [7:0]            div_r;
   logic                  tick;
   logic [TIMER_W-1:0]    timer_r;
   logic [3:0]            hold_r;
   logic [GE_W-1:0]       glob_en_r;
   logic [EP_NUM-1:0]     ep_en_r;
   logic [SINK_W-1:0]     sink_mask_r;
   logic [SINK_W-1:0]     sink_edge_r;
   logic [GPIO_W-1:0]     gpio_mask_r;
   logic [GPIO_PORTS-1:0] gpio_rise_r;
   logic [NUM_SRC-1:0]    pend_r;
   logic [NUM_SRC-1:0]    pend_nxt;
   logic [NUM_SRC-1:0]    src_evt;
   logic [NUM_SRC-1:0]    src_en;
   logic [NUM_SRC-1:0]    serv;
   logic [3:0]            win_idx;
   logic                  t_short_prev_r;
   logic                  t_long_prev_r;
   logic [SINK_W-1:0]     sink_edge_evt;
   logic [GPIO_W-1:0]     gpio_edge_evt;
   logic [GPIO_W-1:0]     gpio_rise_pin;
   logic [7:0]            rdata_r;
   logic [7:0]            rdata_nxt;
   irq_vec_s              irq_r;
   logic                  wr_go;
   logic                  rd_go;
   logic                  taken;

   assign wr_go = reg_req_i.wr;
   assign rd_go = reg_req_i.rd;
   assign taken = irq_ack_i & irq_r.valid;

   ////////////////////////////////////////////////////////////////////////
   // 1 MHz time base and free-running timer

   // divider yields a one-cycle tick every TICK_DIV clocks
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         div_r <= 8'h00;
      end else if (div_r == 8'(TICK_DIV - 1)) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end
   assign tick = (div_r == 8'(TICK_DIV - 1));

   // timer wraps at 12 bits; differences of readings give microseconds
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         timer_r <= '0;
      end else if (tick) begin
         timer_r <= timer_r + 12'h001;
      end
   end

   // tap history for rising-edge detection on bits 6 and 9
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         t_short_prev_r <= 1'b0;
         t_long_prev_r  <= 1'b0;
      end else begin
         t_short_prev_r <= timer_r[T_SHORT_BIT];
         t_long_prev_r  <= timer_r[T_LONG_BIT];
      end
   end

   // reading the low byte freezes the high nibble for a coherent pair
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         hold_r <= 4'h0;
      end else if (rd_go && reg_req_i.addr == ADDR_TMR_LO) begin
         hold_r <= timer_r[11:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software-written configuration

   // enables cleared by every reset so nothing fires before firmware opts in
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         glob_en_r   <= '0;
         ep_en_r     <= '0;
         sink_mask_r <= '0;
         sink_edge_r <= '0;
         gpio_mask_r <= '0;
         gpio_rise_r <= '0;
      end else if (wr_go) begin
         if (reg_req_i.addr == ADDR_GLOBAL_EN) begin
            glob_en_r <= reg_req_i.wdata[GE_W-1:0];
         end
         if (reg_req_i.addr == ADDR_EP_EN) begin
            ep_en_r <= reg_req_i.wdata[EP_NUM-1:0];
         end
         if (reg_req_i.addr == ADDR_SINK_MASK) begin
            sink_mask_r <= reg_req_i.wdata[SINK_W-1:0];
         end
         if (reg_req_i.addr == ADDR_SINK_EDGE) begin
            sink_edge_r <= reg_req_i.wdata[SINK_W-1:0];
         end
         if (reg_req_i.addr == ADDR_GPIO_CFG) begin
            gpio_rise_r <= reg_req_i.wdata[GPIO_PORTS-1:0];
         end
         for (int p = 0; p < GPIO_PORTS; p++) begin
            if (reg_req_i.addr == ADDR_GPIO_MASK0 + 8'(p)) begin
               gpio_mask_r[p*8 +: 8] <= reg_req_i.wdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin edge detection

   // one port-wide polarity bit fans out to its eight pins
   always_comb begin
      for (int p = 0; p < GPIO_PORTS; p++) begin
         gpio_rise_pin[p*8 +: 8] = {8{gpio_rise_r[p]}};
      end
   end

   pin_edge_sync #(
      .W (SINK_W)
   ) u_sink_edge (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (sink_pin_i),
      .rise_i    (sink_edge_r),
      .edge_o    (sink_edge_evt)
   );

   pin_edge_sync #(
      .W (GPIO_W)
   ) u_gpio_edge (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (gpio_pin_i),
      .rise_i    (gpio_rise_pin),
      .edge_o    (gpio_edge_evt)
   );

   ////////////////////////////////////////////////////////////////////////
   // source events and enables, in vector order

   always_comb begin
      src_evt = '0;
      src_evt[SRC_BUSRST] = bus_reset_evt_i;
      src_evt[SRC_T128]   = timer_r[T_SHORT_BIT] & ~t_short_prev_r;
      src_evt[SRC_T1024]  = timer_r[T_LONG_BIT] & ~t_long_prev_r;
      src_evt[SRC_EP0 +: EP_NUM] = ep_evt_i;
      src_evt[SRC_SINK]   = |(sink_edge_evt & sink_mask_r);
      src_evt[SRC_GPIO]   = |(gpio_edge_evt & gpio_mask_r);
      src_evt[SRC_I2C]    = i2c_evt_i;
   end

   always_comb begin
      src_en = '0;
      src_en[SRC_BUSRST] = glob_en_r[GE_BUSRST];
      src_en[SRC_T128]   = glob_en_r[GE_T128];
      src_en[SRC_T1024]  = glob_en_r[GE_T1024];
      src_en[SRC_EP0 +: EP_NUM] = ep_en_r;
      src_en[SRC_SINK]   = glob_en_r[GE_SINK];
      src_en[SRC_GPIO]   = glob_en_r[GE_GPIO];
      src_en[SRC_I2C]    = glob_en_r[GE_I2C];
   end

   ////////////////////////////////////////////////////////////////////////
   // pending flags: latched regardless of enable, so early events wait

   // a new event in the acknowledge cycle wins over the clear
   always_comb begin
      pend_nxt = pend_r;
      if (taken) begin
         pend_nxt[irq_r.idx] = 1'b0;
      end
      pend_nxt = pend_nxt | src_evt;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pend_r <= '0;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // priority pick and vector to the core

   // serviceable only with both the source enable and the core's flag
   assign serv = pend_r & src_en & {NUM_SRC{global_en_i}};

   // lowest index, hence lowest vector address, wins
   always_comb begin
      win_idx = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (serv[i]) begin
            win_idx = 4'(i);
         end
      end
   end

   // request drops for one cycle after a take so the stale slot is not reused
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         irq_r.valid <= 1'b0;
         irq_r.idx   <= 4'h0;
         irq_r.addr  <= RESET_VECTOR;
      end else if (taken) begin
         irq_r.valid <= 1'b0;
      end else begin
         irq_r.valid <= |serv;
         irq_r.idx   <= win_idx;
         irq_r.addr  <= vec_of(win_idx);
      end
   end

   assign irq_o = irq_r;

   ////////////////////////////////////////////////////////////////////////
   // register read path, answer one cycle after the strobe

   // write-only and unmapped addresses read as zero
   always_comb begin
      rdata_nxt = REG_RESET;
      unique case (reg_req_i.addr)
         ADDR_GLOBAL_EN: rdata_nxt = {{(8-GE_W){1'b0}}, glob_en_r};
         ADDR_EP_EN:     rdata_nxt = {{(8-EP_NUM){1'b0}}, ep_en_r};
         ADDR_PEND_LO:   rdata_nxt = pend_r[7:0];
         ADDR_PEND_HI:   rdata_nxt = {5'h00, pend_r[NUM_SRC-1:8]};
         ADDR_TMR_LO:    rdata_nxt = timer_r[7:0];
         ADDR_TMR_HI:    rdata_nxt = {4'h0, hold_r};
         ADDR_GPIO_CFG:  rdata_nxt = {{(8-GPIO_PORTS){1'b0}}, gpio_rise_r};
         default:        rdata_nxt = REG_RESET;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= REG_RESET;
      end else if (rd_go) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= REG_RESET;
      end
   end

   assign reg_rdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_low_read;
      rd_go && reg_req_i.addr == ADDR_TMR_LO;
   endsequence

   sequence s_high_read;
      rd_go && reg_req_i.addr == ADDR_TMR_HI;
   endsequence

   a_timer_step: assert property (tick |=> timer_r == $past(timer_r) + 12'h001)
      else $error("timer did not advance on tick");

   a_tick_spacing: assert property (tick |=> (!tick)[*8])
      else $error("time base ticks too close");

   a_short_tap: assert property ($rose(timer_r[T_SHORT_BIT]) |-> src_evt[SRC_T128] ##1 pend_r[SRC_T128])
      else $error("short period tap not latched");

   a_long_tap: assert property ($changed(timer_r[T_LONG_BIT]) |-> src_evt[SRC_T1024] == timer_r[T_LONG_BIT])
      else $error("long tap edge misjudged");

   a_hold_capture: assert property (s_low_read |=> hold_r == $past(timer_r[11:8]))
      else $error("high nibble not captured");

   a_high_coherent: assert property (s_low_read ##1 s_high_read |=> reg_rdata_o == {4'h0, $past(hold_r)})
      else $error("high read not from holding register");

   a_high_reserved: assert property (s_high_read |=> reg_rdata_o[7:4] == 4'h0)
      else $error("reserved timer bits not zero");

   a_enables_cleared: assert property ($rose(rst_n_i) |-> glob_en_r == '0 && ep_en_r == '0)
      else $error("enables survive reset");

   a_early_busrst: assert property (bus_reset_evt_i && !glob_en_r[GE_BUSRST] |=> pend_r[SRC_BUSRST] && !serv[SRC_BUSRST])
      else $error("early bus reset lost or served");

   a_no_core_flag: assert property (!global_en_i |=> !irq_o.valid || $past(serv) != '0)
      else $error("request without core enable");

   a_vector_map: assert property (irq_o.valid |-> irq_o.addr == vec_of(irq_o.idx) && irq_o.addr != RESERVED_VECTOR
                                  && irq_o.addr < USER_BASE)
      else $error("vector outside table");

   a_lowest_first: assert property (serv != '0 && !taken |=> irq_o.valid && irq_o.idx == $past(win_idx)
                                    && ($past(serv) & ((11'h001 << irq_o.idx) - 11'h001)) == '0)
      else $error("lower vector skipped");

   a_take_clears: assert property (taken && !src_evt[irq_r.idx] |=> !irq_o.valid && !pend_r[$past(irq_r.idx)])
      else $error("accepted request still pending");

endmodule

/* File: rtl/irq_timer_pkg.sv */
package irq_timer_pkg;

   // clock and time base
   localparam int CLK_HZ         = 100_000_000;
   localparam int TICK_HZ        = 1_000_000;
   localparam int TICK_DIV       = CLK_HZ / TICK_HZ;
   localparam int TIMER_W        = 12;
   localparam int T_SHORT_US     = 128;
   localparam int T_LONG_US      = 1024;
   localparam int T_SHORT_BIT    = 6;
   localparam int T_LONG_BIT     = 9;

   // register offsets (byte-wide i/o space)
   localparam logic [7:0] ADDR_GPIO_MASK0 = 8'h04;
   localparam logic [7:0] ADDR_GPIO_CFG   = 8'h08;
   localparam logic [7:0] ADDR_GLOBAL_EN  = 8'h20;
   localparam logic [7:0] ADDR_EP_EN      = 8'h21;
   localparam logic [7:0] ADDR_PEND_LO    = 8'h22;
   localparam logic [7:0] ADDR_PEND_HI    = 8'h23;
   localparam logic [7:0] ADDR_TMR_LO     = 8'h24;
   localparam logic [7:0] ADDR_TMR_HI     = 8'h25;
   localparam logic [7:0] ADDR_SINK_MASK  = 8'h31;
   localparam logic [7:0] ADDR_SINK_EDGE  = 8'h32;
   localparam logic [7:0] REG_RESET       = 8'h00;

   // global enable field positions
   localparam int GE_BUSRST = 0;
   localparam int GE_T128   = 1;
   localparam int GE_T1024  = 2;
   localparam int GE_SINK   = 3;
   localparam int GE_GPIO   = 4;
   localparam int GE_I2C    = 5;
   localparam int GE_W      = 6;
   localparam int EP_NUM    = 5;

   // sources, ordered by vector address (lowest index wins)
   localparam int NUM_SRC   = 11;
   localparam int SRC_BUSRST = 0;
   localparam int SRC_T128  = 1;
   localparam int SRC_T1024 = 2;
   localparam int SRC_EP0   = 3;
   localparam int SRC_SINK  = 8;
   localparam int SRC_GPIO  = 9;
   localparam int SRC_I2C   = 10;

   // program memory map
   localparam int VEC_W = 14;
   localparam logic [VEC_W-1:0] RESET_VECTOR    = 14'h0000;
   localparam logic [VEC_W-1:0] FIRST_VECTOR    = 14'h0002;
   localparam logic [VEC_W-1:0] RESERVED_VECTOR = 14'h0012;
   localparam logic [VEC_W-1:0] USER_BASE       = 14'h001A;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

   typedef struct packed {
      logic             valid;
      logic [3:0]       idx;
      logic [VEC_W-1:0] addr;
   } irq_vec_s;

   // two-byte slots from the first vector, skipping the reserved slot
   function automatic logic [VEC_W-1:0] vec_of(input logic [3:0] idx);
      logic [VEC_W-1:0] v;
      v = FIRST_VECTOR + {9'h000, idx, 1'b0};
      if (idx >= 4'(SRC_SINK)) begin
         v = v + 14'h0002;
      end
      return v;
   endfunction

endpackage

/* File: rtl/pin_edge_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser plus selectable edge detect, one lane per pin
module pin_edge_sync #(
   parameter int W = 8
) (
   input  wire logic         ref_clk_i,  // system clock
   input  wire logic         rst_n_i,    // sync reset, active low
   input  wire logic [W-1:0] pin_i,      // asynchronous pin levels
   input  wire logic [W-1:0] rise_i,     // 1 rising, 0 falling
   output logic      [W-1:0] edge_o      // one-cycle edge pulse
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   // first flop feeds only the second
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // per-lane polarity choice
   assign edge_o = (rise_i & sync_r & ~prev_r) | (~rise_i & ~sync_r & prev_r);
endmodule

/* File: sim/core_model.sv */
`timescale 1ns/1ps
// stand-in for the processor core: global enable flag and vector accept
module core_model
   import irq_timer_pkg::*;
(
   input  wire logic                    ref_clk_i,   // system clock
   input  wire logic                    rst_n_i,     // sync reset, active low
   input  wire irq_timer_pkg::irq_vec_s irq_i,       // request and vector
   input  wire logic                    ei_i,        // enable instruction done
   input  wire logic [3:0]              delay_i,     // cycles before accept
   output logic                         global_en_o, // core global enable
   output logic                         ack_o,       // accept pulse
   output logic [7:0]                   taken_o,     // accepted vector count
   output logic [3:0]                   idx_o,       // last accepted source
   output logic [VEC_W-1:0]             addr_o       // last accepted vector
);
   logic [3:0] wait_r;
   ////////////////////////////////////////
   // flag is cleared by any reset and set only by the instruction
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         global_en_o <= 1'b0;
      end else begin
         global_en_o <= ei_i;
      end
   end
   // pulse drops at the edge that takes it, so no request is taken twice
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ack_o   <= 1'b0;
         wait_r  <= 4'h0;
         taken_o <= 8'h00;
         idx_o   <= 4'h0;
         addr_o  <= RESET_VECTOR;
      end else if (ack_o) begin
         ack_o   <= 1'b0;
         wait_r  <= 4'h0;
         taken_o <= taken_o + 8'h01;
         idx_o   <= irq_i.idx;
         addr_o  <= irq_i.addr;
      end else if (irq_i.valid) begin
         if (wait_r == delay_i) begin
            ack_o <= 1'b1;
         end else begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule

/* File: sim/test_vectored_irq_and_free_timer.sv */
`timescale 1ns/1ps
module test_vectored_irq_and_free_timer;
   import irq_timer_pkg::*;
   logic             clk, rst_n, bus_rst, i2c_evt, ei, gen, ack;
   logic [4:0]       ep_evt;
   logic [7:0]       sink_pin, rdata, taken, a, b;
   logic [31:0]      gpio_pin;
   logic [3:0]       delay, t_idx;
   logic [VEC_W-1:0] t_addr;
   reg_req_s         req;
   irq_vec_s         irq;
   int               bad_count, num_checks, cyc, c1;

   vectored_irq_and_free_timer u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_req_i(req),
      .reg_rdata_o(rdata), .bus_reset_evt_i(bus_rst), .ep_evt_i(ep_evt), .i2c_evt_i(i2c_evt),
      .sink_pin_i(sink_pin), .gpio_pin_i(gpio_pin), .global_en_i(gen), .irq_ack_i(ack), .irq_o(irq));
   core_model u_core (.ref_clk_i(clk), .rst_n_i(rst_n), .irq_i(irq), .ei_i(ei), .delay_i(delay),
      .global_en_o(gen), .ack_o(ack), .taken_o(taken), .idx_o(t_idx), .addr_o(t_addr));

   ////////////////////////////////////////
   // clock and a cycle ceiling well above the long timer wait
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         bad_count++;
         test_done();
      end
   end
   task test_done;
      if (bad_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   // vector slots worked out by hand, reserved slot skipped
   function automatic logic [15:0] exp_vec(input int n);
      case (n)
         8: return 16'h0014;
         9: return 16'h0016;
         10: return 16'h0018;
         default: return 16'h0002 + 16'(2 * n);
      endcase
   endfunction
   task reg_wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk) req <= '{ad, d, 1'b1, 1'b0};
      @(posedge clk) req <= '0;
   endtask
   task reg_rd(input logic [7:0] ad, output logic [7:0] d);
      @(posedge clk) req <= '{ad, 8'h00, 1'b0, 1'b1};
      @(posedge clk) req <= '0;
      #1 d = rdata;
   endtask
   // low byte then high nibble back to back, as firmware reads the pair
   task rd_pair(output logic [7:0] lo, output logic [7:0] hi);
      @(posedge clk) req <= '{ADDR_TMR_LO, 8'h00, 1'b0, 1'b1};
      @(posedge clk) req <= '{ADDR_TMR_HI, 8'h00, 1'b0, 1'b1};
      #1 lo = rdata;
      @(posedge clk) req <= '0;
      #1 hi = rdata;
   endtask
   task rd_chk(input logic [7:0] ad, input logic [7:0] e);
      logic [7:0] d;
      reg_rd(ad, d);
      chk({8'h00, d}, {8'h00, e}, "read");
   endtask
   task fire(input logic br, input logic [4:0] ep, input logic ic);
      @(posedge clk) {bus_rst, ep_evt, i2c_evt} <= {br, ep, ic};
      @(posedge clk) {bus_rst, ep_evt, i2c_evt} <= 7'h00;
   endtask
   // wait for one accepted vector and judge its source and address
   task take(input int n, input int lim);
      logic [7:0] base;
      base = taken;
      repeat (lim) begin
         @(posedge clk);
         #1;
         if (taken !== base) break;
      end
      chk({8'h00, taken}, {8'h00, base + 8'h01}, "accept count");
      chk({12'h000, t_idx}, 16'(n), "source");
      chk({2'b00, t_addr}, exp_vec(n), "vector");
   endtask
   task quiet(input int lim);
      logic [7:0] base;
      base = taken;
      repeat (lim) @(posedge clk);
      #1 chk({8'h00, taken}, {8'h00, base}, "no request");
   endtask
   ////////////////////////////////////////
   // outputs judged just after reset is released, before the first live edge moves them
   task do_reset;
      @(posedge clk) rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk({15'h0000, irq.valid}, 16'h0000, "valid after reset");
      chk({2'b00, irq.addr}, 16'h0000, "reset vector");
      rd_chk(ADDR_GLOBAL_EN, 8'h00);
      rd_chk(ADDR_EP_EN, 8'h00);
   endtask
   task t_regs;
      reg_wr(ADDR_EP_EN, 8'h1F);
      rd_chk(ADDR_EP_EN, 8'h1F);
      reg_wr(ADDR_GLOBAL_EN, 8'h3F);
      rd_chk(ADDR_GLOBAL_EN, 8'h3F);
      reg_wr(ADDR_SINK_MASK, 8'hFF);
      rd_chk(ADDR_SINK_MASK, 8'h00);
      reg_wr(ADDR_SINK_EDGE, 8'hFF);
      rd_chk(ADDR_SINK_EDGE, 8'h00);
      reg_wr(8'h40, 8'h55);
      rd_chk(8'h40, 8'h00);
      reg_wr(ADDR_GLOBAL_EN, 8'h00);
   endtask
   // everything pends while the core is closed, then drains lowest first
   task t_prio;
      int order [7];
      order = '{0, 3, 4, 5, 6, 7, 10};
      delay <= 4'h3;
      reg_wr(ADDR_GLOBAL_EN, 8'h20);
      fire(1'b1, 5'h1F, 1'b1);
      quiet(12);
      rd_chk(ADDR_PEND_LO, 8'hF9);
      rd_chk(ADDR_PEND_HI, 8'h04);
      reg_wr(ADDR_GLOBAL_EN, 8'h21);
      quiet(12);
      ei <= 1'b1;
      foreach (order[i]) take(order[i], 20);
      quiet(20);
      delay <= 4'h0;
   endtask
   task pin(input logic [7:0] s, input logic [31:0] g, input int n);
      @(posedge clk) {sink_pin, gpio_pin} <= {s, g};
      if (n < 0) quiet(14);
      else take(n, 14);
   endtask
   task t_pins;
      reg_wr(ADDR_GLOBAL_EN, 8'h18);
      reg_wr(ADDR_SINK_MASK, 8'h05);
      reg_wr(ADDR_SINK_EDGE, 8'h01);
      reg_wr(ADDR_GPIO_MASK0, 8'h80);
      reg_wr(ADDR_GPIO_MASK0 + 8'h01, 8'h01);
      reg_wr(ADDR_GPIO_CFG, 8'h02);
      rd_chk(ADDR_GPIO_CFG, 8'h02);
      rd_chk(ADDR_GPIO_MASK0, 8'h00);
      pin(8'h02, 32'h0, -1);
      pin(8'h03, 32'h0, 8);
      pin(8'h07, 32'h0, -1);
      pin(8'h03, 32'h0, 8);
      pin(8'h03, 32'h80, -1);
      pin(8'h03, 32'h0, 9);
      pin(8'h03, 32'h100, 9);
      pin(8'h03, 32'h300, -1);
   endtask
   task t_timer;
      reg_wr(ADDR_GLOBAL_EN, 8'h00);
      reg_rd(ADDR_TMR_LO, a);
      rd_chk(ADDR_TMR_HI, 8'h00);
      // samples exactly 1000 clocks apart, so exactly ten ticks whatever the divider phase
      repeat (996) @(posedge clk);
      reg_rd(ADDR_TMR_LO, b);
      chk({8'h00, b - a}, 16'h000A, "elapsed ticks");
      reg_wr(ADDR_GLOBAL_EN, 8'h02);
      take(1, 13000);
      take(1, 13000);
      c1 = cyc;
      take(1, 13000);
      chk(16'(cyc - c1), 16'd12800, "short period");
      reg_wr(ADDR_GLOBAL_EN, 8'h04);
      take(2, 21000);
      rd_chk(ADDR_TMR_HI, 8'h00);
      rd_pair(a, b);
      chk({8'h00, b}, 16'h0002, "paired high nibble");
   endtask
   ////////////////////////////////////////
   initial begin
      {rst_n, bus_rst, i2c_evt, ei, ep_evt, sink_pin, gpio_pin, delay} = '0;
      req = '0;
      do_reset();
      t_regs();
      t_prio();
      t_pins();
      t_timer();
      do_reset();
      test_done();
   end
endmodule
